// *** frcs_bench.sv ***
/*
 * Self-checking bench: a host model drives APB, the bench drives the
 * neighbouring levels, the cable pin and completion reports.
 * Assumes zero-wait APB answers and a pin synchroniser of a few edges.
 */
`timescale 1ns/1ps
`default_nettype none

module frcs_bench;
	import frcs_pkg::*;

	logic                   pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [FRCS_ADDR_W-1:0] paddr;
	logic [31:0]            pwdata, prdata, seed, rd, wd;
	logic [3:0]             pstrb, if_mode_bits;
	logic                   dma_gate_mirror, dor_reset_hold, dsr_reset_pulse;
	logic                   media_swapped_n, cmd_done, positioning_done, track_zero_fault;
	logic                   head_now, end_of_track, crc_fault, service_late, sector_missing;
	logic                   write_protected_fault, id_sync_missing, precomp_off, density_out;
	logic                   core_soft_reset, m_pre, f_en, f_val, err, ok;
	frcs_term_t             termination_code;
	logic [1:0]             unit_number, rate_sel, m_rate, v;
	logic [7:0]             result_zero, result_one;
	int                     err_count, comparisons;

	frcs_host frcs_host_inst (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));

	frcs_top frcs_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .if_mode_bits(if_mode_bits),
		.dma_gate_mirror(dma_gate_mirror), .dor_reset_hold(dor_reset_hold),
		.dsr_reset_pulse(dsr_reset_pulse), .media_swapped_n(media_swapped_n),
		.cmd_done(cmd_done), .termination_code(termination_code),
		.positioning_done(positioning_done), .track_zero_fault(track_zero_fault),
		.head_now(head_now), .unit_number(unit_number), .end_of_track(end_of_track),
		.crc_fault(crc_fault), .service_late(service_late), .sector_missing(sector_missing),
		.write_protected_fault(write_protected_fault), .id_sync_missing(id_sync_missing),
		.rate_sel(rate_sel), .precomp_off(precomp_off), .density_out(density_out),
		.core_soft_reset(core_soft_reset), .result_zero(result_zero),
		.result_one(result_one));

	// Free-running 20 MHz clock.
	initial
	begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic final_report();
		$display("counts: %0d compared, %0d bad", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : final_report

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			err_count++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// A stalled bus ends the run, since nothing after it could be trusted.
	task automatic bus(input logic wr, input logic [FRCS_ADDR_W-1:0] a, input logic [31:0] d);
		frcs_host_inst.xfer(wr, a, d, rd, err, ok);
		if (!ok)
		begin
			err_count++;
			$display("BAD t=%0t bus stalled", $time);
			final_report();
		end
	endtask : bus

	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask : cyc

	// Several shifts per call so that neighbouring draws share few bits.
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		for (int j = 0; j < 11; j++)
			s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
		return s;
	endfunction : lfsr

	// Model of the disk input byte for the layout in force.
	function automatic logic [7:0] din_exp();
		logic chg;
		chg = f_en ? f_val : ~media_swapped_n;
		case (if_mode_bits[3:2])
			2'b10:   return {chg, 4'hF, m_rate, m_rate[1]};
			2'b00:   return {chg, 3'h0, dma_gate_mirror, m_pre, m_rate};
			default: return {chg, 7'h00};
		endcase
	endfunction : din_exp

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial
	begin
		{presetn, dma_gate_mirror, dor_reset_hold, dsr_reset_pulse, cmd_done} = 5'h00;
		{positioning_done, track_zero_fault, head_now, end_of_track, crc_fault} = 5'h00;
		{service_late, sector_missing, write_protected_fault, id_sync_missing} = 4'h0;
		{unit_number, if_mode_bits, f_en, f_val, m_pre} = 9'h000;
		media_swapped_n = 1'b1;
		termination_code = FRCS_TERM_NORMAL;
		seed = 32'd87491;
		m_rate = FRCS_RATE_RESET;
		cyc(5);
		presetn <= 1'b1;
		cyc(8);
		check(rate_sel, FRCS_RATE_RESET);
		check(density_out, 1'b1);
		bus(1'b0, 14'hFDC, 32'h0);
		check(rd, din_exp());
		$display("test reset values done");
		// Every layout code, with random rates, mirrors and pin levels.
		for (int i = 0; i < 12; i++)
		begin
			seed = lfsr(seed);
			if_mode_bits    <= {i[1:0], seed[1:0]};
			dma_gate_mirror <= seed[2];
			media_swapped_n <= seed[3];
			cyc(8);
			wd = {29'h0, (i[1:0] == 2'b00) & seed[6], seed[5:4]};
			bus(1'b1, 14'hFDC, wd);
			m_rate = seed[5:4];
			if (i[1:0] == 2'b00)
				m_pre = seed[6];
			bus(1'b0, 14'hFDC, 32'h0);
			check(rd, din_exp());
			check({density_out, precomp_off, rate_sel}, {m_rate[1], m_pre, m_rate});
			bus(1'b0, 14'hFE8, 32'h0);
			check(rd, {m_pre, m_rate});
		end
		$display("test layouts done");
		// Both software reset sources; the held one outlasts the pulse.
		dsr_reset_pulse <= 1'b1;
		dor_reset_hold  <= 1'b1;
		@(posedge pclk);
		dsr_reset_pulse <= 1'b0;
		#1 check(core_soft_reset, 1'b1);
		@(posedge pclk);
		dor_reset_hold <= 1'b0;
		#1 check(core_soft_reset, 1'b0);
		cyc(2);
		check(core_soft_reset, 1'b0);
		check({density_out, precomp_off, rate_sel}, {m_rate[1], m_pre, m_rate});
		// Hardware reset in mid-run must restore rate code, precomp bit and density.
		if_mode_bits <= 4'h0;
		cyc(2);
		bus(1'b1, 14'hFDC, 32'h5);
		m_rate = 2'b01;
		m_pre = 1'b1;
		cyc(1);
		check({density_out, precomp_off, rate_sel}, {m_rate[1], m_pre, m_rate});
		presetn <= 1'b0;
		cyc(2);
		presetn <= 1'b1;
		m_rate = FRCS_RATE_RESET;
		m_pre = 1'b0;
		cyc(8);
		check({density_out, precomp_off, rate_sel}, {1'b1, m_pre, m_rate});
		bus(1'b0, 14'hFDC, 32'h0);
		check(rd, din_exp());
		$display("test soft reset done");
		// Forced change flag: on high, on low, then back to the pin.
		for (int k = 0; k < 3; k++)
		begin
			v = 2'd3 - k[1:0];
			bus(1'b1, 14'h078, {30'h0, v});
			{f_en, f_val} = v;
			media_swapped_n <= k[0];
			cyc(8);
			bus(1'b0, 14'hFDC, 32'h0);
			check(rd, din_exp());
		end
		$display("test forced flag done");
		// Each termination code twice, with random fields and event pulses.
		for (int t = 0; t < 8; t++)
		begin
			seed = lfsr(seed);
			{end_of_track, crc_fault, service_late} <= seed[2:0];
			{sector_missing, write_protected_fault, id_sync_missing} <= seed[5:3];
			@(posedge pclk);
			{end_of_track, crc_fault, service_late, sector_missing} <= 4'h0;
			{write_protected_fault, id_sync_missing} <= 2'h0;
			cmd_done <= 1'b1;
			termination_code <= frcs_term_t'(t[1:0]);
			{positioning_done, track_zero_fault, head_now, unit_number} <= seed[10:6];
			@(posedge pclk);
			cmd_done <= 1'b0;
			cyc(3);
			check(result_zero, {t[1:0], seed[10:9], 1'b0, seed[8:6]});
			wd = {seed[2], 1'b0, seed[1], seed[0], 1'b0, seed[5:3]};
			check(result_one, wd);
			bus(1'b0, 14'hFE0, 32'h0);
			check(rd, {24'h0, t[1:0], seed[10:9], 1'b0, seed[8:6]});
			bus(1'b0, 14'hFE4, 32'h0);
			check(rd, wd);
		end
		$display("test result bytes done");
		// Unmapped place: refused, reads zero, write has no effect.
		bus(1'b1, 14'h100, 32'h3);
		check(err, 1'b1);
		bus(1'b0, 14'h100, 32'h0);
		check({err, rd}, {1'b1, 32'h0});
		check(rate_sel, m_rate);
		$display("test unmapped done");
		final_report();
	end

endmodule : frcs_bench

`default_nettype wire

// *** frcs_host.sv ***
/*
 * Host processor model: an APB master that runs one transfer per call.
 * Assumes the slave raises pready; a stall past the bound is reported back.
 */
`timescale 1ns/1ps
`default_nettype none

module frcs_host
(
	// Bus clock.
	input  wire logic                            pclk,
	// Master request.
	output var  logic                            psel,
	output var  logic                            penable,
	output var  logic                            pwrite,
	output var  logic [frcs_pkg::FRCS_ADDR_W-1:0] paddr,
	output var  logic [31:0]                     pwdata,
	output var  logic [3:0]                      pstrb,
	// Slave answer.
	input  wire logic [31:0]                     prdata,
	input  wire logic                            pready,
	input  wire logic                            pslverr
);
	import frcs_pkg::*;

	// Idle bus at time zero; all byte lanes are always enabled.
	initial
	begin
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = '0;
		pwdata  = '0;
		pstrb   = 4'hF;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Setup then access; the request is held until pready is seen at an edge, for at most 16 edges.
	task automatic xfer(input logic wr, input logic [FRCS_ADDR_W-1:0] a,
			input logic [31:0] wd, output logic [31:0] rd, output logic err,
			output logic ok);
		ok = 1'b0;
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		for (int i = 0; i < 16 && !ok; i++)
		begin
			@(posedge pclk);
			ok  = pready;
			rd  = prdata;
			err = pslverr;
		end
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : xfer

endmodule : frcs_host

`default_nettype wire

// *** frcs_pkg.sv ***
/*
 * Shared constants for the floppy rate, configuration and result status block.
 * Assumes an APB slave with 32-bit data and word-aligned registers.
 */
`default_nettype none

package frcs_pkg;

	// Printed offset 0x3F7 is not a multiple of four, so it is kept as an index.
	localparam logic [11:0] FRCS_IDX_DISK_INPUT = 12'h3F7;
	localparam logic [11:0] FRCS_IDX_RESULT     = 12'h3F8;
	localparam logic [11:0] FRCS_IDX_EVENTS     = 12'h3F9;
	localparam logic [11:0] FRCS_IDX_MISC       = 12'h3FA;
	localparam logic [11:0] FRCS_IDX_FORCE_CHG  = 12'h01E;
	localparam int          FRCS_ADDR_W         = 14;

	// Register layouts selected by interface mode bits 3:2.
	typedef enum logic [1:0]
	{
		FRCS_MODE_LEGACY = 2'b11,
		FRCS_MODE_ALT    = 2'b10,
		FRCS_MODE_THIRD  = 2'b00
	} frcs_mode_t;

	// Termination codes in result byte 0 bits 7:6.
	typedef enum logic [1:0]
	{
		FRCS_TERM_NORMAL  = 2'b00,
		FRCS_TERM_ABORT   = 2'b01,
		FRCS_TERM_INVALID = 2'b10,
		FRCS_TERM_POLL    = 2'b11
	} frcs_term_t;

	// Rate code for 250 Kbps after hardware reset.
	localparam logic [1:0] FRCS_RATE_RESET = 2'b10;

	// Field positions.
	localparam int FRCS_BIT_CHG     = 7;
	localparam int FRCS_BIT_DMA     = 3;
	localparam int FRCS_BIT_PRECOMP = 2;
	localparam int FRCS_BIT_NHD     = 0;

	// Result byte 0 positions.
	localparam int FRCS_S0_POSDONE = 5;
	localparam int FRCS_S0_TRACK_ZERO_INPUT    = 4;
	localparam int FRCS_S0_HEAD    = 2;

	// Result byte 1 positions.
	localparam int FRCS_S1_ENDCYL = 7;
	localparam int FRCS_S1_CRC    = 5;
	localparam int FRCS_S1_OVR    = 4;
	localparam int FRCS_S1_NODATA = 2;
	localparam int FRCS_S1_WPROT  = 1;
	localparam int FRCS_S1_NOMARK = 0;

	// Number of status events captured into result byte 1.
	localparam int FRCS_EVT_N = 6;

endpackage : frcs_pkg

`default_nettype wire

// *** frcs_result.sv ***
/*
 * Builds the two result status bytes from command completion events.
 * Assumes the command sequencer pulses done once per finished command.
 */
`timescale 1ns/1ps
`default_nettype none

module frcs_result
	import frcs_pkg::*;
(
	// Clock and reset.
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	// Completion report.
	input  wire logic                  done,
	input  wire frcs_pkg::frcs_term_t  term,
	input  wire logic                  pos_done,
	input  wire logic                  track_zero_input_fault,
	input  wire logic                  head,
	input  wire logic [1:0]            unit_number,
	input  wire logic [FRCS_EVT_N-1:0] events,
	// Bytes.
	output var  logic [7:0]            status_zero,
	output var  logic [7:0]            status_one
);

	logic [FRCS_EVT_N-1:0] evt_seen;
	logic [7:0]            next_one;

	////////////////////////////////////////////////////////////////////////////
	// Events latch during the command and fold into byte 1 at completion.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			evt_seen <= '0;
		else if (done)
			evt_seen <= '0;
		else
			evt_seen <= evt_seen | events;
	end

	// Map the six event sources onto their byte 1 positions.
	always_comb
	begin
		next_one                 = 8'h00;
		next_one[FRCS_S1_ENDCYL] = evt_seen[5] | events[5];
		next_one[FRCS_S1_CRC]    = evt_seen[4] | events[4];
		next_one[FRCS_S1_OVR]    = evt_seen[3] | events[3];
		next_one[FRCS_S1_NODATA] = evt_seen[2] | events[2];
		next_one[FRCS_S1_WPROT]  = evt_seen[1] | events[1];
		next_one[FRCS_S1_NOMARK] = evt_seen[0] | events[0];
	end

	// Capture both bytes for the command just completed.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			status_zero <= 8'h00;
			status_one  <= 8'h00;
		end
		else if (done)
		begin
			status_zero <= {term, pos_done, track_zero_input_fault, 1'b0, head, unit_number};
			status_one  <= next_one;
		end
	end

	chk_byte1_bit6: assert property (@(posedge pclk) disable iff (!presetn)
		status_one[6] == 1'b0 && status_one[3] == 1'b0)
		else $error("Unused result bits set.");

endmodule : frcs_result

`default_nettype wire

// *** frcs_sync.sv ***
/*
 * Three-stage synchroniser for a pin input; the output changes only once
 * the second and third stages agree.
 * Assumes the pin is asynchronous to pclk.
 */
`timescale 1ns/1ps
`default_nettype none

module frcs_sync
	import frcs_pkg::*;
(
	// Clock and reset.
	input  wire logic pclk,
	input  wire logic presetn,
	// Pin and result.
	input  wire logic pin,
	output var  logic level
);

	logic s1;
	logic s2;
	logic s3;

	////////////////////////////////////////////////////////////////////////////
	// Only the second stage reads the first, so metastability stays contained.
	// Reset to the idle-high pin level, so no false change shows after reset.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s1    <= 1'b1;
			s2    <= 1'b1;
			s3    <= 1'b1;
			level <= 1'b1;
		end
		else
		begin
			s1 <= pin;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3)
				level <= s3;
		end
	end

endmodule : frcs_sync

`default_nettype wire

// *** frcs_top.sv ***
/*
 * Floppy controller rate configuration, disk input register and result status.
 * Assumes an APB master on pclk, and that drive output register bits and
 * interface mode arrive as same-clock levels from the neighbouring logic.
 */
`timescale 1ns/1ps
`default_nettype none

module frcs_top
	import frcs_pkg::*;
(
	// APB slave.
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [FRCS_ADDR_W-1:0] paddr,
	input  wire logic [31:0]            pwdata,
	input  wire logic [3:0]             pstrb,
	output var  logic [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	// Neighbouring register state.
	input  wire logic [3:0]             if_mode_bits,
	input  wire logic                   dma_gate_mirror,
	input  wire logic                   dor_reset_hold,
	input  wire logic                   dsr_reset_pulse,
	// Drive cable.
	input  wire logic                   media_swapped_n,
	// Command completion report.
	input  wire logic                   cmd_done,
	input  wire frcs_pkg::frcs_term_t   termination_code,
	input  wire logic                   positioning_done,
	input  wire logic                   track_zero_fault,
	input  wire logic                   head_now,
	input  wire logic [1:0]             unit_number,
	input  wire logic                   end_of_track,
	input  wire logic                   crc_fault,
	input  wire logic                   service_late,
	input  wire logic                   sector_missing,
	input  wire logic                   write_protected_fault,
	input  wire logic                   id_sync_missing,
	// Outputs.
	output var  logic [1:0]             rate_sel,
	output var  logic                   precomp_off,
	output var  logic                   density_out,
	output logic                        core_soft_reset,
	output var  logic [7:0]             result_zero,
	output var  logic [7:0]             result_one
);
	import frcs_pkg::*;

	localparam logic [FRCS_ADDR_W-1:0] A_INPUT  = {FRCS_IDX_DISK_INPUT, 2'b00};
	localparam logic [FRCS_ADDR_W-1:0] A_RESULT = {FRCS_IDX_RESULT, 2'b00};
	localparam logic [FRCS_ADDR_W-1:0] A_EVENTS = {FRCS_IDX_EVENTS, 2'b00};
	localparam logic [FRCS_ADDR_W-1:0] A_MISC   = {FRCS_IDX_MISC, 2'b00};
	localparam logic [FRCS_ADDR_W-1:0] A_FORCE  = {FRCS_IDX_FORCE_CHG, 2'b00};

	frcs_mode_t            mode;
	logic                  disk_chg_pin;
	logic                  force_chg;
	logic                  force_en;
	logic                  swapped_bit;
	logic [7:0]            disk_input;
	logic                  wr_en;
	logic                  rd_en;
	logic                  mapped;
	logic [FRCS_EVT_N-1:0] evt_bus;
	logic [7:0]            next_rdata;

	////////////////////////////////////////////////////////////////////////////
	// Layout select; an unused code falls back to the legacy layout.
	always_comb
	begin
		unique case (if_mode_bits[3:2])
			2'b10:   mode = FRCS_MODE_ALT;
			2'b00:   mode = FRCS_MODE_THIRD;
			default: mode = FRCS_MODE_LEGACY;
		endcase
	end

	// The cable pin is asynchronous, so it passes three stages first.
	frcs_sync u_sync
	(
		.pclk    (pclk),
		.presetn (presetn),
		.pin     (media_swapped_n),
		.level   (disk_chg_pin)
	);

	// Forced value wins over the cable when enabled.
	assign swapped_bit = force_en ? force_chg : ~disk_chg_pin;

	////////////////////////////////////////////////////////////////////////////
	// APB decode: zero-wait slave; unmapped addresses answer with pslverr.
	assign pready  = 1'b1;
	assign mapped  = (paddr == A_INPUT) || (paddr == A_RESULT) || (paddr == A_EVENTS)
		|| (paddr == A_MISC) || (paddr == A_FORCE);
	assign pslverr = psel && penable && !mapped;
	assign wr_en   = psel && penable && pwrite && pstrb[0];
	assign rd_en   = psel && !penable && !pwrite;

	// Software reset: drive output hold and the self-clearing pulse are ORed; either one asserts it.
	assign core_soft_reset = dor_reset_hold | dsr_reset_pulse;

	////////////////////////////////////////////////////////////////////////////
	// Rate bits and precompensation-off: only hardware reset touches them.
	// The software reset deliberately does not appear here.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rate_sel    <= FRCS_RATE_RESET;
			precomp_off <= 1'b0;
		end
		else if (wr_en && paddr == A_INPUT)
		begin
			rate_sel <= pwdata[1:0];
			// Bit 2 is reserved outside the third layout.
			if (mode == FRCS_MODE_THIRD)
				precomp_off <= pwdata[FRCS_BIT_PRECOMP];
		end
	end

	// Force register for the disk-changed bit.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			force_en  <= 1'b0;
			force_chg <= 1'b0;
		end
		else if (wr_en && paddr == A_FORCE)
		begin
			force_en  <= pwdata[1];
			force_chg <= pwdata[0];
		end
	end

	// Density output: set by hardware reset, high for the lower rates.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			density_out <= 1'b1;
		else if (wr_en && paddr == A_INPUT)
			density_out <= pwdata[1];
	end

	////////////////////////////////////////////////////////////////////////////
	// Disk input register per layout.
	always_comb
	begin
		disk_input = 8'h00;
		disk_input[FRCS_BIT_CHG] = swapped_bit;
		unique case (mode)
			FRCS_MODE_ALT:
			begin
				disk_input[6:3] = 4'hF;
				disk_input[2:1] = rate_sel;
				disk_input[FRCS_BIT_NHD] = rate_sel[1];
			end
			FRCS_MODE_THIRD:
			begin
				disk_input[FRCS_BIT_DMA]     = dma_gate_mirror;
				disk_input[FRCS_BIT_PRECOMP] = precomp_off;
				disk_input[1:0]              = rate_sel;
			end
			FRCS_MODE_LEGACY:
				disk_input[6:0] = 7'h00;
		endcase
	end

	// Read mux for the setup cycle.
	always_comb
	begin
		next_rdata = 8'h00;
		unique case (paddr)
			A_INPUT:  next_rdata = disk_input;
			A_RESULT: next_rdata = result_zero;
			A_EVENTS: next_rdata = result_one;
			A_MISC:   next_rdata = {5'h00, precomp_off, rate_sel};
			A_FORCE:  next_rdata = {6'h00, force_en, force_chg};
			default:  next_rdata = 8'h00;
		endcase
	end

	// Read data registered in the setup cycle, valid through the access phase.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (rd_en)
			prdata <= {24'h00_0000, next_rdata};
	end

	////////////////////////////////////////////////////////////////////////////
	// Result bytes.
	assign evt_bus = {end_of_track, crc_fault, service_late, sector_missing,
		write_protected_fault, id_sync_missing};

	frcs_result u_result
	(
		.pclk        (pclk),
		.presetn     (presetn),
		.done        (cmd_done),
		.term        (termination_code),
		.pos_done    (positioning_done),
		.track_zero_input_fault  (track_zero_fault),
		.head        (head_now),
		.unit_number (unit_number),
		.events      (evt_bus),
		.status_zero (result_zero),
		.status_one  (result_one)
	);

	////////////////////////////////////////////////////////////////////////////
	// Checks.
	chk_alt_ones_read: assert property (@(posedge pclk) disable iff (!presetn)
		mode == FRCS_MODE_ALT |-> disk_input[6:3] == 4'hF)
		else $error("Alternate layout bits 3 to 6 not one.");

	chk_chg_inverse: assert property (@(posedge pclk) disable iff (!presetn)
		!force_en |-> disk_input[FRCS_BIT_CHG] == ~disk_chg_pin)
		else $error("Disk changed bit not inverted pin.");

	chk_rate_soft_keep: assert property (@(posedge pclk) disable iff (!presetn)
		!(wr_en && paddr == A_INPUT) |=> rate_sel == $past(rate_sel))
		else $error("Rate bits changed without a write.");

	chk_dma_mirror: assert property (@(posedge pclk) disable iff (!presetn)
		mode == FRCS_MODE_THIRD |-> disk_input[FRCS_BIT_DMA] == dma_gate_mirror)
		else $error("DMA gate mirror wrong.");

	chk_precomp_mirror: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_en && paddr == A_INPUT && mode == FRCS_MODE_THIRD) ##1 mode == FRCS_MODE_THIRD
		|-> disk_input[FRCS_BIT_PRECOMP] == $past(pwdata[FRCS_BIT_PRECOMP]))
		else $error("Precomp bit not mirrored.");

	chk_third_zeros: assert property (@(posedge pclk) disable iff (!presetn)
		mode == FRCS_MODE_THIRD |-> disk_input[6:4] == 3'b000)
		else $error("Third layout bits 4 to 6 not zero.");

	chk_density_hold: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(core_soft_reset) && !(wr_en && paddr == A_INPUT) |=> $stable(density_out))
		else $error("Density output moved on software reset.");

	chk_term_capture: assert property (@(posedge pclk) disable iff (!presetn)
		cmd_done |=> result_zero[7:6] == $past(termination_code) && result_zero[3] == 1'b0)
		else $error("Termination code not captured.");

	chk_crc_report: assert property (@(posedge pclk) disable iff (!presetn)
		cmd_done && crc_fault |=> result_one[FRCS_S1_CRC])
		else $error("CRC fault not reported.");

	chk_soft_prec: assert property (@(posedge pclk) disable iff (!presetn)
		dor_reset_hold |-> core_soft_reset)
		else $error("Drive output reset not dominant.");

endmodule : frcs_top

`default_nettype wire
